// ---- bench/ssr_motor_model.sv ----
// power stage and motor model giving the measured current, power and power factor values
`timescale 1ns/1ps
module ssr_motor_model (
  input wire logic [7:0] volt_pct,
  input wire logic motor_on,
  input wire logic lock,
  output logic [ssr_pkg::DW-1:0] meas_cur_pct,
  output logic [ssr_pkg::DW-1:0] meas_cur_amp,
  output logic [ssr_pkg::DW-1:0] meas_act_pwr,
  output logic [ssr_pkg::DW-1:0] meas_pf
);
  import ssr_pkg::*;
  // a stalled rotor draws well above the default limit of 300
  assign meas_cur_pct = (lock && motor_on) ? 16'h0190 :
                        16'h0020 + {8'h00, volt_pct};
  assign meas_cur_amp = {meas_cur_pct[14:0], 1'b0};
  assign meas_act_pwr = 16'h0100 + {8'h00, volt_pct};
  assign meas_pf = 16'h0055;
endmodule

// ---- bench/ssr_soft_start_sva.sv ----
// assertion checker for the soft-start controller ports
`timescale 1ns/1ps
module ssr_soft_start_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ssr_pkg::AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ssr_pkg::DW-1:0] reg_rdata,
  input wire logic stop_cmd,
  input wire logic [ssr_pkg::DW-1:0] meas_cur_amp,
  input wire logic [7:0] meas_thermal,
  input wire logic bypass_on,
  input wire logic energy_save_on,
  input wire logic [7:0] volt_pct,
  input wire logic motor_on,
  input wire logic [7:0] error_code,
  input wire logic param_flash
);
  import ssr_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_trip_thermal;
    (ce && motor_on && meas_thermal >= TH_TRIP) |=> !motor_on;
  endproperty
  a_trip_thermal: assert property (p_trip_thermal)
    else $error("motor kept running at thermal trip level");
  property p_trip_code;
    (ce && motor_on && meas_thermal >= TH_TRIP) |=> error_code == CODE_THERMAL;
  endproperty
  a_trip_code: assert property (p_trip_code)
    else $error("thermal trip shows wrong code");
  property p_err_off;
    (error_code != 8'h00) |-> !motor_on;
  endproperty
  a_err_off: assert property (p_err_off)
    else $error("motor on while a fault is shown");
  property p_pwr_off;
    (ce && reg_rd && reg_addr == OFS_ACT_PWR && (bypass_on || energy_save_on))
      |=> reg_rdata == PWR_OFF_CODE;
  endproperty
  a_pwr_off: assert property (p_pwr_off)
    else $error("power reading not off under bypass");
  property p_cur_amp;
    (ce && reg_rd && reg_addr == OFS_CUR_AMP)
      |=> reg_rdata == $past(meas_cur_amp);
  endproperty
  a_cur_amp: assert property (p_cur_amp)
    else $error("ampere reading differs from measurement");
  property p_init_range;
    $rose(motor_on) |-> volt_pct >= INIT_V_MIN && volt_pct <= INIT_V_MAX;
  endproperty
  a_init_range: assert property (p_init_range)
    else $error("start voltage out of range");
  property p_ramp_step;
    (motor_on && $past(motor_on) && volt_pct > $past(volt_pct))
      |-> volt_pct == $past(volt_pct) + 8'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp rose by more than one step");
  property p_full_cap;
    volt_pct <= FULL_V;
  endproperty
  a_full_cap: assert property (p_full_cap)
    else $error("voltage above full");
  property p_stop_drop;
    (ce && stop_cmd && motor_on) |=> volt_pct <= $past(volt_pct);
  endproperty
  a_stop_drop: assert property (p_stop_drop)
    else $error("voltage rose after ramp-down command");
  property p_flash_cause;
    $rose(param_flash) |-> $past(reg_wr);
  endproperty
  a_flash_cause: assert property (p_flash_cause)
    else $error("flash without a write");
endmodule
bind ssr_soft_start ssr_soft_start_chk chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .stop_cmd(stop_cmd), .meas_cur_amp(meas_cur_amp),
  .meas_thermal(meas_thermal), .bypass_on(bypass_on),
  .energy_save_on(energy_save_on), .volt_pct(volt_pct),
  .motor_on(motor_on), .error_code(error_code), .param_flash(param_flash)
);

// ---- bench/tb.sv ----
// self-checking bench for the soft-start controller
`timescale 1ns/1ps
module tb;
  import ssr_pkg::*;
  logic core_clk, sys_rst, ce, reg_wr, reg_rd, start_cmd, stop_cmd;
  logic fault_reset, ext_fault, bypass_on, energy_save_on, lock;
  logic motor_on, param_flash, irq;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, cur_pct, cur_amp, act_pwr, pf;
  logic [7:0] ext_fault_code, meas_thermal, volt_pct, error_code;
  int num_errors, checked, waited;
  // ------------------------------------------------------------
  // design and motor model
  // ------------------------------------------------------------
  // short sub-tick keeps one ramp second at 1024 cycles
  ssr_soft_start #(.SUBTICK_CYCLES(4)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .fault_reset(fault_reset), .ext_fault(ext_fault),
    .ext_fault_code(ext_fault_code), .meas_cur_pct(cur_pct),
    .meas_cur_amp(cur_amp), .meas_act_pwr(act_pwr), .meas_pf(pf),
    .meas_thermal(meas_thermal), .bypass_on(bypass_on),
    .energy_save_on(energy_save_on), .volt_pct(volt_pct),
    .motor_on(motor_on), .error_code(error_code),
    .param_flash(param_flash), .irq(irq));
  ssr_motor_model model (
    .volt_pct(volt_pct), .motor_on(motor_on), .lock(lock),
    .meas_cur_pct(cur_pct), .meas_cur_amp(cur_amp),
    .meas_act_pwr(act_pwr), .meas_pf(pf));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic strobe(input int k, input logic v);
    @(posedge core_clk);
    case (k)
      0: start_cmd <= v;
      1: stop_cmd <= v;
      2: fault_reset <= v;
      default: ext_fault <= v;
    endcase
  endtask
  // 0 start, 1 stop, 2 fault reset, 3 external fault
  task automatic pulse(input int k);
    strobe(k, 1'b1);
    strobe(k, 1'b0);
    #1;
  endtask
  task automatic wait_volt(input logic [7:0] v, input int lim);
    waited = 0;
    while (volt_pct !== v && waited < lim) begin
      @(posedge core_clk);
      #1;
      waited++;
    end
    chk(16'(volt_pct), 16'(v));
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {sys_rst, ce} = 2'b11;
    {reg_wr, reg_rd, start_cmd, stop_cmd, fault_reset, ext_fault} = '0;
    {bypass_on, energy_save_on, lock} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    ext_fault_code = '0;
    meas_thermal = '0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_INIT_V, 16'(INIT_V_DEF));
    rd(OFS_ACCEL_T, 16'(ACCEL_T_DEF));
    rd(OFS_DSTEP, 16'(DSTEP_DEF));
    wr(OFS_INIT_V, 16'h0028);
    rd(OFS_INIT_V, 16'(INIT_V_DEF));
    wr(OFS_ACCESS, 16'h0001);
    wr(OFS_INIT_V, 16'(INIT_V_MIN));
    rd(OFS_INIT_V, 16'(INIT_V_MIN));
    wr(OFS_INIT_V, 16'(INIT_V_MAX + 8'h01));
    rd(OFS_INIT_V, 16'(INIT_V_MIN));
    chk(16'(param_flash), 16'h0001);
    wr(OFS_ACCEL_T, 16'(ACCEL_T_MIN));
    wr(OFS_IRQ_MASK, 16'h0001);
    pulse(0);
    chk(16'(volt_pct), 16'(INIT_V_MIN));
    wait_volt(FULL_V, 1200);
    chk(16'(waited >= 1000), 16'h0001);
    chk(16'(irq), 16'h0000);
    wr(OFS_INIT_V, 16'h0020);
    rd(OFS_INIT_V, 16'(INIT_V_MIN));
    pulse(1);
    chk({7'h00, motor_on, volt_pct}, 16'h0000);
    wr(OFS_DECEL_T, 16'h0001);
    wr(OFS_DSTEP, 16'(DSTEP_MIN));
    pulse(0);
    wait_volt(FULL_V, 1200);
    pulse(1);
    chk({7'h00, motor_on, volt_pct}, {8'h01, DSTEP_MIN});
    // clock enable low must freeze the ramp-down where it stands
    ce <= 1'b0;
    repeat (300) @(posedge core_clk);
    ce <= 1'b1;
    #1;
    chk(16'(volt_pct), 16'(DSTEP_MIN));
    wait_volt(8'h00, 1200);
    // stalled rotor: ramp time becomes the protection limit
    lock <= 1'b1;
    pulse(0);
    wait_volt(8'h00, 1300);
    chk(16'(waited >= 1000), 16'h0001);
    chk(16'(error_code), 16'(CODE_LOCKED));
    chk(16'(irq), 16'h0001);
    rd(OFS_HIST, 16'(CODE_LOCKED));
    pulse(2);
    chk(16'(error_code), 16'h0000);
    wr(OFS_IRQ_ST, 16'h0001);
    rd(OFS_IRQ_ST, 16'h0006);
    chk(16'(irq), 16'h0000);
    wr(OFS_VPULSE, 16'h0001);
    pulse(0);
    wait_volt(FULL_V, 1200);
    pulse(1);
    wait_volt(8'h00, 1200);
    lock <= 1'b0;
    pulse(0);
    meas_thermal <= TH_TRIP;
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, motor_on, error_code}, 16'(CODE_THERMAL));
    rd(OFS_THERMAL, 16'(TH_TRIP));
    repeat (20) @(posedge core_clk);
    rd(OFS_HIST, 16'(CODE_THERMAL));
    rd(OFS_HIST + 8'h04, 16'(CODE_LOCKED));
    meas_thermal <= 8'h00;
    pulse(2);
    for (int i = 0; i < 4; i++) begin
      ext_fault_code <= 8'h10 + 8'(i);
      pulse(3);
      pulse(2);
    end
    for (int i = 0; i < 4; i++) begin
      rd(OFS_HIST + 8'(i * 4), 16'(8'h13 - 8'(i)));
    end
    rd(OFS_CUR_PCT, 16'h0020);
    rd(OFS_CUR_AMP, 16'h0040);
    rd(OFS_ACT_PWR, 16'h0100);
    rd(OFS_PF, 16'h0055);
    bypass_on <= 1'b1;
    rd(OFS_ACT_PWR, PWR_OFF_CODE);
    bypass_on <= 1'b0;
    energy_save_on <= 1'b1;
    rd(OFS_PF, PWR_OFF_CODE);
    energy_save_on <= 1'b0;
    wr(OFS_ACCESS, 16'h0000);
    wr(OFS_DSTEP, 16'h0050);
    rd(OFS_DSTEP, 16'(DSTEP_MIN));
    // a reset in mid-run must revoke change permission again
    wr(OFS_ACCESS, 16'h0001);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    wr(OFS_DSTEP, 16'h0050);
    rd(OFS_DSTEP, 16'(DSTEP_DEF));
    rd(8'hFC, 16'h0000);
    print_verdict();
  end
endmodule

// ---- rtl/ssr_fault_hist.sv ----
// four-entry fault history memory with registered read port
`timescale 1ns/1ps
module ssr_fault_hist (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic push,
  input wire logic [7:0] push_code,
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data
);
  import ssr_pkg::*;
  logic [7:0] ent_q [4];
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        ent_q[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else if (ce) begin
      if (push) begin
        ent_q[0] <= push_code; // R01
        for (int i = 1; i < 4; i++) begin
          ent_q[i] <= ent_q[i-1]; // R01
        end
      end
      rd_data <= ent_q[rd_idx];
    end
  end
endmodule

// ---- rtl/ssr_pkg.sv ----
// constants, register map and types of the soft-start ramp controller
// Notes on behaviour
// R01: a history of the four newest fault codes shifts one place older on each new fault and drops the oldest.
// R02: parameters can be changed only while the access control is on, and are always readable.
// R03: a start begins at the initial voltage, 25 to 90 percent of rated line voltage in 1 percent steps, default 30.
// R04: the voltage rises from the initial value to full over the ramp time, 1 s to 240 s, default 20 s, unless current limiting holds it.
// R05: while current limiting acts during a start, the ramp time becomes a locked-rotor time limit instead.
// R06: a ramp-down command drops the voltage at once to the step level, 100 down to 40 percent, default 100, before the ramp down.
// R07: the step and the ramp down happen only when the ramp-down time is nonzero; otherwise the motor switches off.
// R08: the thermal state reads 0 to 250; at 250 the motor trips and shows code 4.
// R09: active power and power factor read as the off code while the bypass or energy saving is in use.
// R10: output current reads both as a percentage of rated current and in amperes, read-only.
// R11: current limiting is disabled while the start voltage pulse is enabled.
// R12: a stop-only parameter written while the motor runs is rejected and the stored value flashes.
// R13: change permission is off after reset and when the access control is written off.
// R14: each fault event enters the history once, when first detected, not again while it persists; the code pushes ext_fault on every cycle it stays high.
package ssr_pkg;
  // ------------------------------------------------------------
  // bus and widths
  // ------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int ACC_W = 17;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_ACCESS = 8'h00;
  localparam logic [7:0] OFS_INIT_V = 8'h04;
  localparam logic [7:0] OFS_ACCEL_T = 8'h08;
  localparam logic [7:0] OFS_DSTEP = 8'h0C;
  localparam logic [7:0] OFS_DECEL_T = 8'h10;
  localparam logic [7:0] OFS_ILIM = 8'h14;
  localparam logic [7:0] OFS_VPULSE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_CUR_PCT = 8'h24;
  localparam logic [7:0] OFS_CUR_AMP = 8'h28;
  localparam logic [7:0] OFS_ACT_PWR = 8'h2C;
  localparam logic [7:0] OFS_PF = 8'h30;
  localparam logic [7:0] OFS_THERMAL = 8'h34;
  localparam logic [7:0] OFS_IRQ_ST = 8'h38;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h3C;
  localparam logic [7:0] OFS_HIST = 8'h40;
  localparam logic [7:0] OFS_HIST_END = 8'h4C;
  // ------------------------------------------------------------
  // reset values and ranges
  // ------------------------------------------------------------
  localparam logic [7:0] INIT_V_DEF = 8'h1E;
  localparam logic [7:0] INIT_V_MIN = 8'h19;
  localparam logic [7:0] INIT_V_MAX = 8'h5A;
  localparam logic [7:0] ACCEL_T_DEF = 8'h14;
  localparam logic [7:0] ACCEL_T_MIN = 8'h01;
  localparam logic [7:0] ACCEL_T_MAX = 8'hF0;
  localparam logic [7:0] DSTEP_DEF = 8'h64;
  localparam logic [7:0] DSTEP_MIN = 8'h28;
  localparam logic [7:0] DSTEP_MAX = 8'h64;
  localparam logic [7:0] DECEL_T_DEF = 8'h00;
  localparam logic [7:0] DECEL_T_MAX = 8'hF0;
  localparam logic [15:0] ILIM_DEF = 16'h012C;
  localparam logic [7:0] FULL_V = 8'h64;
  localparam logic [7:0] TH_TRIP = 8'hFA;
  localparam logic [15:0] PWR_OFF_CODE = 16'hFFFF;
  localparam logic [7:0] CODE_LOCKED = 8'h02;
  localparam logic [7:0] CODE_THERMAL = 8'h04;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // ------------------------------------------------------------
  // timing: ramp time counted in 1/256 second sub-ticks
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 200_000_000;
  localparam int RAMP_UNIT_S = 1;
  localparam int SUB_PER_S = 256;
  localparam int SUBTICK_CYC = int'(CLK_HZ * RAMP_UNIT_S / SUB_PER_S);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACCEL, ST_RUN, ST_DECEL, ST_TRIP
  } ssr_state_t;
endpackage

// ---- rtl/ssr_soft_start.sv ----
// soft-start ramp, protection and parameter register block
`timescale 1ns/1ps
module ssr_soft_start #(
  parameter int unsigned SUBTICK_CYCLES = ssr_pkg::SUBTICK_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ssr_pkg::AW-1:0] reg_addr,
  input wire logic [ssr_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ssr_pkg::DW-1:0] reg_rdata,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic fault_reset,
  input wire logic ext_fault,
  input wire logic [7:0] ext_fault_code,
  input wire logic [ssr_pkg::DW-1:0] meas_cur_pct,
  input wire logic [ssr_pkg::DW-1:0] meas_cur_amp,
  input wire logic [ssr_pkg::DW-1:0] meas_act_pwr,
  input wire logic [ssr_pkg::DW-1:0] meas_pf,
  input wire logic [7:0] meas_thermal,
  input wire logic bypass_on,
  input wire logic energy_save_on,
  output logic [7:0] volt_pct,
  output logic motor_on,
  output logic [7:0] error_code,
  output logic param_flash,
  output logic irq
);
  import ssr_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one bresenham step: carry out in the top bit, remainder below
  function automatic logic [ACC_W:0] bres(
    input logic [ACC_W-1:0] acc,
    input logic [7:0] delta,
    input logic [7:0] secs
  );
    logic [ACC_W-1:0] s;
    logic [ACC_W-1:0] span;
    span = {1'b0, secs, 8'h00};
    s = acc + {9'h000, delta};
    if (s >= span) begin
      bres = {1'b1, s - span};
    end else begin
      bres = {1'b0, s};
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ssr_state_t st_q, st_d;
  logic [7:0] volt_q, volt_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [7:0] sec_q, sec_d;
  logic [7:0] dlev_q, dlev_d;
  logic access_q;
  logic [7:0] init_v_q, accel_t_q, dstep_q, decel_t_q;
  logic [15:0] ilim_q;
  logic vpulse_q;
  logic flash_q;
  logic [7:0] err_q;
  logic th_prev_q;
  logic [2:0] irq_st_q, irq_mask_q;
  logic [DW-1:0] rdata_q;
  logic hist_sel_q;
  logic [7:0] hist_rd;
  logic sub_p, sec_p;

  // ------------------------------------------------------------
  // register write decode
  // ------------------------------------------------------------
  wire [7:0] wd8 = reg_wdata[7:0];
  wire running = st_q == ST_ACCEL || st_q == ST_RUN || st_q == ST_DECEL;
  wire param_addr = reg_addr >= OFS_INIT_V && reg_addr <= OFS_VPULSE;
  wire param_wr = reg_wr && param_addr;
  wire hi_zero = reg_wdata[15:8] == 8'h00;
  wire in_range =
    (reg_addr == OFS_INIT_V) ? hi_zero && wd8 >= INIT_V_MIN &&
                               wd8 <= INIT_V_MAX :
    (reg_addr == OFS_ACCEL_T) ? hi_zero && wd8 >= ACCEL_T_MIN &&
                                wd8 <= ACCEL_T_MAX :
    (reg_addr == OFS_DSTEP) ? hi_zero && wd8 >= DSTEP_MIN &&
                              wd8 <= DSTEP_MAX :
    (reg_addr == OFS_DECEL_T) ? hi_zero && wd8 <= DECEL_T_MAX :
    (reg_addr == OFS_VPULSE) ? reg_wdata[15:1] == 15'h0000 :
    1'b1;
  // the initial voltage and the voltage pulse cannot change under a running motor
  wire stop_only = reg_addr == OFS_INIT_V || reg_addr == OFS_VPULSE;
  wire accept = param_wr && access_q && in_range &&
                !(stop_only && running); // R02 R12
  wire reject = param_wr && access_q && !accept; // R12
  wire wr_ok_init = accept && reg_addr == OFS_INIT_V;
  wire wr_ok_accel = accept && reg_addr == OFS_ACCEL_T;
  wire wr_ok_dstep = accept && reg_addr == OFS_DSTEP;
  wire wr_ok_decel = accept && reg_addr == OFS_DECEL_T;
  wire wr_ok_ilim = accept && reg_addr == OFS_ILIM;
  wire wr_ok_vpulse = accept && reg_addr == OFS_VPULSE;
  wire wr_access = reg_wr && reg_addr == OFS_ACCESS;
  wire wr_irq_clr = reg_wr && reg_addr == OFS_IRQ_ST;
  wire wr_irq_mask = reg_wr && reg_addr == OFS_IRQ_MASK;

  // ------------------------------------------------------------
  // protection and fault detection
  // ------------------------------------------------------------
  wire ilim_act = st_q == ST_ACCEL && !vpulse_q &&
                  meas_cur_pct >= ilim_q; // R11
  wire lr_fault = ilim_act && sec_q >= accel_t_q; // R05
  wire th_hot = meas_thermal >= TH_TRIP; // R08
  wire th_new = th_hot && !th_prev_q; // R14
  wire lr_new = lr_fault; // leaves accel at once, so one-shot
  wire fault_push = th_new || lr_new || ext_fault; // R14
  // simultaneous faults keep only the most serious code
  wire [7:0] fault_code = th_new ? CODE_THERMAL :
                          lr_new ? CODE_LOCKED : ext_fault_code;
  wire ramp_done = st_q == ST_ACCEL && st_d == ST_RUN;
  wire [2:0] irq_ev = {ramp_done, reject, fault_push};

  // ------------------------------------------------------------
  // ramp sequencer
  // ------------------------------------------------------------
  wire [7:0] up_delta = FULL_V - init_v_q;
  wire [ACC_W:0] up_step = bres(acc_q, up_delta, accel_t_q);
  wire [ACC_W:0] dn_step = bres(acc_q, dlev_q, decel_t_q);
  wire [7:0] step_lvl = (volt_q < dstep_q) ? volt_q : dstep_q;

  always_comb begin
    st_d = st_q;
    volt_d = volt_q;
    acc_d = acc_q;
    sec_d = sec_q;
    dlev_d = dlev_q;
    if (fault_push) begin
      st_d = ST_TRIP; // R08
      volt_d = 8'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start_cmd) begin
            st_d = ST_ACCEL;
            volt_d = init_v_q; // R03
            acc_d = '0;
            sec_d = 8'h00;
          end
        end
        ST_ACCEL, ST_RUN: begin
          if (stop_cmd) begin
            acc_d = '0;
            if (decel_t_q != 8'h00) begin // R07
              st_d = ST_DECEL;
              volt_d = step_lvl; // R06
              dlev_d = step_lvl;
            end else begin
              st_d = ST_IDLE;
              volt_d = 8'h00;
            end
          end else if (st_q == ST_ACCEL) begin
            if (sec_p && sec_q != 8'hFF) begin
              sec_d = sec_q + 8'h01; // R05
            end
            // limiting holds the voltage where it is
            if (sub_p && !ilim_act) begin
              acc_d = up_step[ACC_W-1:0]; // R04
              if (up_step[ACC_W]) begin
                volt_d = volt_q + 8'h01; // R04
              end
            end
            if (volt_q >= FULL_V) begin
              st_d = ST_RUN; // R04
              volt_d = FULL_V;
            end
          end
        end
        ST_DECEL: begin
          if (volt_q == 8'h00) begin
            st_d = ST_IDLE;
          end else if (sub_p) begin
            acc_d = dn_step[ACC_W-1:0];
            if (dn_step[ACC_W]) begin
              volt_d = volt_q - 8'h01;
            end
          end
        end
        ST_TRIP: begin
          volt_d = 8'h00;
          if (fault_reset && !th_hot) begin
            st_d = ST_IDLE;
          end
        end
        default: begin
          st_d = ST_IDLE;
          volt_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      volt_q <= 8'h00;
      acc_q <= '0;
      sec_q <= 8'h00;
      dlev_q <= 8'h00;
    end else if (ce) begin
      st_q <= st_d;
      volt_q <= volt_d;
      acc_q <= acc_d;
      sec_q <= sec_d;
      dlev_q <= dlev_d;
    end
  end

  // ------------------------------------------------------------
  // parameter registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      access_q <= 1'b0; // R13
    end else if (ce && wr_access) begin
      access_q <= reg_wdata[0]; // R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      init_v_q <= INIT_V_DEF; // R03
      accel_t_q <= ACCEL_T_DEF; // R04
      dstep_q <= DSTEP_DEF; // R06
      decel_t_q <= DECEL_T_DEF;
      ilim_q <= ILIM_DEF;
      vpulse_q <= 1'b0;
    end else if (ce) begin
      if (wr_ok_init) init_v_q <= wd8;
      if (wr_ok_accel) accel_t_q <= wd8;
      if (wr_ok_dstep) dstep_q <= wd8;
      if (wr_ok_decel) decel_t_q <= wd8;
      if (wr_ok_ilim) ilim_q <= reg_wdata;
      if (wr_ok_vpulse) vpulse_q <= reg_wdata[0];
    end
  end

  // ------------------------------------------------------------
  // fault, flash and interrupt state
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flash_q <= 1'b0;
      err_q <= 8'h00;
      th_prev_q <= 1'b0;
      irq_st_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
    end else if (ce) begin
      // flashing lasts until a value is accepted or access ends
      if (reject) begin
        flash_q <= 1'b1; // R12
      end else if (accept || (wr_access && !reg_wdata[0])) begin
        flash_q <= 1'b0;
      end
      if (fault_push) begin
        err_q <= fault_code; // R08
      end else if (st_q == ST_TRIP && st_d == ST_IDLE) begin
        err_q <= 8'h00;
      end
      th_prev_q <= th_hot; // R14
      // a new event wins over a clear in the same cycle
      irq_st_q <= (irq_st_q & ~({3{wr_irq_clr}} & reg_wdata[2:0]))
                  | irq_ev;
      if (wr_irq_mask) begin
        irq_mask_q <= reg_wdata[2:0];
      end
    end
  end

  ssr_tick #(
    .SUBTICK_CYCLES(SUBTICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run(st_q == ST_ACCEL || st_q == ST_DECEL),
    .sub_p(sub_p),
    .sec_p(sec_p)
  );

  ssr_fault_hist u_hist (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .push(fault_push), // R01 R14
    .push_code(fault_code),
    .rd_idx(reg_addr[3:2]),
    .rd_data(hist_rd)
  );

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  wire pwr_off = bypass_on || energy_save_on;
  wire hist_addr = reg_addr >= OFS_HIST && reg_addr <= OFS_HIST_END &&
                   reg_addr[1:0] == 2'b00;
  wire [DW-1:0] status_val = {4'h0, access_q, ilim_act,
                              st_q == ST_TRIP, running, volt_q};
  wire [DW-1:0] rd_val =
    (reg_addr == OFS_ACCESS) ? {15'h0000, access_q} :
    (reg_addr == OFS_INIT_V) ? {8'h00, init_v_q} :
    (reg_addr == OFS_ACCEL_T) ? {8'h00, accel_t_q} :
    (reg_addr == OFS_DSTEP) ? {8'h00, dstep_q} :
    (reg_addr == OFS_DECEL_T) ? {8'h00, decel_t_q} :
    (reg_addr == OFS_ILIM) ? ilim_q :
    (reg_addr == OFS_VPULSE) ? {15'h0000, vpulse_q} :
    (reg_addr == OFS_STATUS) ? status_val :
    (reg_addr == OFS_CUR_PCT) ? meas_cur_pct : // R10
    (reg_addr == OFS_CUR_AMP) ? meas_cur_amp : // R10
    (reg_addr == OFS_ACT_PWR) ? (pwr_off ? PWR_OFF_CODE :
                                 meas_act_pwr) : // R09
    (reg_addr == OFS_PF) ? (pwr_off ? PWR_OFF_CODE : meas_pf) : // R09
    (reg_addr == OFS_THERMAL) ? {8'h00, meas_thermal} : // R08
    (reg_addr == OFS_IRQ_ST) ? {13'h0000, irq_st_q} :
    (reg_addr == OFS_IRQ_MASK) ? {13'h0000, irq_mask_q} :
    16'h0000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
      hist_sel_q <= 1'b0;
    end else if (ce) begin
      rdata_q <= (reg_rd && !hist_addr) ? rd_val : 16'h0000;
      hist_sel_q <= reg_rd && hist_addr;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata = hist_sel_q ? {8'h00, hist_rd} : rdata_q;
  assign volt_pct = volt_q;
  assign motor_on = running;
  assign error_code = err_q;
  assign param_flash = flash_q;
  assign irq = |(irq_st_q & irq_mask_q);
endmodule

// ---- rtl/ssr_tick.sv ----
// sub-tick and second pulse generator for ramp timing
`timescale 1ns/1ps
module ssr_tick #(
  parameter int unsigned SUBTICK_CYCLES = ssr_pkg::SUBTICK_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic run,
  output logic sub_p,
  output logic sec_p
);
  import ssr_pkg::*;
  localparam int CW = $clog2(SUBTICK_CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic [7:0] sub_q;
  wire wrap = cnt_q == CW'(SUBTICK_CYCLES - 1);
  // counters restart while run is low, so seconds align to each ramp start unless ramp-down follows acceleration directly
  always_ff @(posedge core_clk) begin
    if (sys_rst || (ce && !run)) begin
      cnt_q <= '0;
      sub_q <= '0;
    end else if (ce) begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      if (wrap) begin
        sub_q <= sub_q + 1'b1;
      end
    end
  end
  assign sub_p = ce && run && wrap;
  assign sec_p = sub_p && (sub_q == 8'hFF);
endmodule
